// >>> rtl/psp_pkg.sv
/*
 * Shared constants and types of the power switch serial port: register map,
 * field positions, reset values and ring oscillator timing.
 * Assumes a 200 MHz system clock and an 8-bit APB byte address.
 */
package psp_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0]  PSP_FRAME_OFF   = 8'h00;
  localparam logic [7:0]  PSP_STATUS_OFF  = 8'h04;
  localparam logic [7:0]  PSP_SYSCTL_OFF  = 8'h80;
  localparam logic [31:0] PSP_SYSCTL_RST  = 32'h0000_0000;
  localparam logic [31:0] PSP_FRAME_RST   = 32'h0000_0000;
  localparam logic [31:0] PSP_ZERO_WORD   = 32'h0000_0000;
  localparam int          PSP_CLKDRV_BIT  = 27;
  localparam int          PSP_ST_BUSY     = 0;
  localparam int          PSP_ST_STRAP    = 1;
  localparam int          PSP_ST_SUSP     = 2;
  localparam int          PSP_ST_HIZ      = 3;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int PSP_SYS_PERIOD_NS  = 5;
  localparam int PSP_RING_PERIOD_NS = 62500;
  localparam int PSP_RING_HALF_CYC  = PSP_RING_PERIOD_NS / (2 * PSP_SYS_PERIOD_NS);
  localparam int PSP_STRAP_WAIT     = 3;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic global_reset_input;
    logic bus_reset_input;
    logic susp;
    logic ack;
    logic strobe;
  } psp_sync_in_t;

  typedef enum logic [1:0] {LS_IDLE, LS_SHIFT, LS_STROBE} psp_lstate_t;

endpackage

// >>> rtl/psp_sync.sv
/*
 * Two flip-flop level synchroniser, any width.
 * Assumes every bit is a slow level or a toggle from another domain.
 */
`timescale 1ns/1ps
module psp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;

  // Refused at elaboration, before any logic is built
  if (WIDTH < 1) begin : g_bad_width
    $error("psp_sync: WIDTH must be at least 1");
  end

  // First stage feeds only the second stage
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= '0;
      o_sync   <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end
endmodule

// >>> rtl/psp_clkdiv.sv
/*
 * Divider standing in for the internal ring oscillator: a square wave with a
 * half period of HALF_CYC system clocks while i_run is high, low otherwise.
 * Assumes i_run is synchronous to i_clk.
 */
`timescale 1ns/1ps
module psp_clkdiv #(
  parameter int HALF_CYC = 6250
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_run,
  output logic      o_clk
);
  localparam int CW = $clog2(HALF_CYC + 1);
  logic [CW-1:0] cnt_reg;

  // Refused at elaboration, before any logic is built
  if (HALF_CYC < 1) begin : g_bad_half
    $error("psp_clkdiv: HALF_CYC must be at least 1");
  end

  // Stopped divider parks low, so the switch sees no stray edge
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= '0;
      o_clk   <= 1'b0;
    end else if (!i_run) begin
      cnt_reg <= '0;
      o_clk   <= 1'b0;
    end else if (cnt_reg == CW'(HALF_CYC - 1)) begin
      cnt_reg <= '0;
      o_clk   <= ~o_clk;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule

// >>> rtl/psp_top.sv
/*
 * Power switch serial port: APB registers, reset and suspend handling, the
 * strobe strap, the switch clock direction and the serial frame shifter.
 * Assumes the pad ring resolves each pin from its output enable and feeds
 * the clock pin's pad level back as i_clk_link, also while we drive it.
 */
// The implementer's own choice: the APB interface to the registers.
// Contract
// (R01) Switch samples data on link clock rise
// (R02) Clock pin input at reset; bit 27 drives
// (R03) Link clock stays within 16 to 100 kHz
// (R04) Driven clock comes from ring oscillator
// (R05) Control bits go out serially on data
// (R06) Strobe marks shifted data as valid
// (R07) Strobe pulled low routes EEPROM to pins
// (R08) Global reset: outputs floating, registers cleared
// (R09) Bus reset: outputs floating, registers cleared
// (R10) Suspend: resets ignored, contents kept, floating
// (R11) Global reset only at boot, then bus
// (R12) Data moves off rising edges; strobe last (the shifter moves data and strobe on falling edges of i_clk_link)
`timescale 1ns/1ps
module psp_top
  import psp_pkg::*;
#(
  parameter int FRAME_W       = 16,
  parameter int RING_HALF_CYC = PSP_RING_HALF_CYC
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  input  wire logic        i_global_reset_input,
  input  wire logic        i_bus_reset_input,
  input  wire logic        i_suspend_mode,
  input  wire logic        i_clk_link,
  output logic             o_sw_clk,
  output logic             o_sw_clk_oe,
  output logic             o_sw_data,
  output logic             o_sw_data_oe,
  input  wire logic        i_sw_strobe,
  output logic             o_sw_strobe,
  output logic             o_sw_strobe_oe,
  output logic             o_eeprom_route
);
  localparam int CNT_W = $clog2(FRAME_W);

  // Refused at elaboration: the counter and read mux cover 2 to 32 bits
  if (FRAME_W < 2 || FRAME_W > 32) begin : g_bad_frame
    $error("psp_top: FRAME_W must be 2 to 32");
  end
  if (RING_HALF_CYC < 1) begin : g_bad_ring
    $error("psp_top: RING_HALF_CYC must be at least 1");
  end

  // ****************************************************************
  // Declarations
  // ****************************************************************
  psp_sync_in_t       sin_raw;
  psp_sync_in_t       sin_s;
  logic               hiz;
  logic               soft_clr;
  logic               soft_clr_reg;
  logic [31:0]        sysctl_reg;
  logic [FRAME_W-1:0] frame_reg;
  logic               req_tgl_reg;
  logic               busy;
  logic [1:0]         strap_cnt_reg;
  logic               strap_done_reg;
  logic               clk_drive;
  logic               div_clk;
  logic               acc;
  logic               done;
  logic               hit;
  logic [31:0]        rd_word;
  logic [1:0]         lsync;
  psp_lstate_t        lstate_reg;
  logic [FRAME_W-1:0] shift_reg;
  logic [CNT_W-1:0]   cnt_reg;
  logic               seen_reg;
  logic               ack_tgl_reg;

  // ****************************************************************
  // Pin inputs and the link acknowledge toggle into the system domain
  // ****************************************************************
  assign sin_raw = '{global_reset_input: i_global_reset_input, bus_reset_input: i_bus_reset_input,
                     susp: i_suspend_mode, ack: ack_tgl_reg, strobe: i_sw_strobe};

  psp_sync #(.WIDTH($bits(psp_sync_in_t))) u_sync_sys (
    .i_clk   (i_clk_sys),
    .i_rst   (i_rst),
    .i_async (sin_raw),
    .o_sync  (sin_s)
  );

  // Suspend shields the registers but never the pins
  assign hiz      = sin_s.global_reset_input | sin_s.bus_reset_input | sin_s.susp;         // R08 R09 R10
  assign soft_clr = (sin_s.global_reset_input | sin_s.bus_reset_input) & ~sin_s.susp;      // R10
  assign busy     = req_tgl_reg ^ sin_s.ack;

  // Flopped for the link domain: a gate output may glitch as it crosses
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      soft_clr_reg <= 1'b0;
    end else begin
      soft_clr_reg <= soft_clr;
    end
  end

  // ****************************************************************
  // APB slave, one wait state
  // ****************************************************************
  assign acc  = i_psel & i_penable;
  assign done = acc & o_pready;
  assign hit  = (i_paddr == PSP_SYSCTL_OFF) | (i_paddr == PSP_FRAME_OFF) |
                (i_paddr == PSP_STATUS_OFF);

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_word = PSP_ZERO_WORD;
    unique case (i_paddr)
      PSP_SYSCTL_OFF: rd_word = sysctl_reg;
      PSP_FRAME_OFF:  rd_word[FRAME_W-1:0] = frame_reg;
      PSP_STATUS_OFF: begin
        rd_word[PSP_ST_BUSY]  = busy;
        rd_word[PSP_ST_STRAP] = o_eeprom_route;
        rd_word[PSP_ST_SUSP]  = sin_s.susp;
        rd_word[PSP_ST_HIZ]   = hiz;
      end
      default:        rd_word = PSP_ZERO_WORD;
    endcase
  end

  // Answer is registered so every bus output comes from a flop
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_prdata  <= PSP_ZERO_WORD;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= acc & ~o_pready;
      if (acc && !o_pready) begin
        o_prdata  <= i_pwrite ? PSP_ZERO_WORD : rd_word;
        o_pslverr <= ~hit;
      end
    end
  end

  // System control register; bit 27 chooses who drives the clock pin
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sysctl_reg <= PSP_SYSCTL_RST;                               // R02
    end else if (soft_clr) begin
      sysctl_reg <= PSP_SYSCTL_RST;                               // R08 R09
    end else if (done && i_pwrite && i_paddr == PSP_SYSCTL_OFF) begin
      sysctl_reg <= i_pwdata;
    end
  end

  // Frame write launches a transfer; ignored while one is in flight, since
  // the link side reads frame_reg without its own copy until it loads
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      frame_reg   <= PSP_FRAME_RST[FRAME_W-1:0];
      req_tgl_reg <= 1'b0;
    end else if (soft_clr) begin
      frame_reg   <= PSP_FRAME_RST[FRAME_W-1:0];                  // R08 R09
    end else if (done && i_pwrite && i_paddr == PSP_FRAME_OFF && !busy) begin
      frame_reg   <= i_pwdata[FRAME_W-1:0];                       // R05
      req_tgl_reg <= ~req_tgl_reg;
    end
  end

  // ****************************************************************
  // Strobe strap and pin enables
  // ****************************************************************
  // Strobe stays undriven until the strap has been read after each reset
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      strap_cnt_reg  <= '0;
      strap_done_reg <= 1'b0;
      o_eeprom_route <= 1'b0;
    end else if (soft_clr) begin
      strap_cnt_reg  <= '0;
      strap_done_reg <= 1'b0;
      o_eeprom_route <= 1'b0;
    end else if (!strap_done_reg && !hiz) begin
      if (strap_cnt_reg == 2'(PSP_STRAP_WAIT)) begin
        strap_done_reg <= 1'b1;
        o_eeprom_route <= ~sin_s.strobe;                          // R07
      end else begin
        strap_cnt_reg <= strap_cnt_reg + 1'b1;
      end
    end
  end

  assign clk_drive = sysctl_reg[PSP_CLKDRV_BIT];

  // All enables drop at once whenever a reset or suspend is seen
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_sw_clk_oe    <= 1'b0;
      o_sw_data_oe   <= 1'b0;
      o_sw_strobe_oe <= 1'b0;
    end else begin
      o_sw_clk_oe    <= clk_drive & ~hiz;                         // R02 R08 R09 R10
      o_sw_data_oe   <= ~hiz;                                     // R08 R09 R10
      o_sw_strobe_oe <= strap_done_reg & ~hiz;                    // R06 R07
    end
  end

  // ****************************************************************
  // Ring oscillator clock
  // ****************************************************************
  psp_clkdiv #(.HALF_CYC(RING_HALF_CYC)) u_ring (
    .i_clk (i_clk_sys),
    .i_rst (i_rst),
    .i_run (clk_drive),                                          // R04
    .o_clk (div_clk)
  );

  // Retimed so the pin leaves a flop of this module
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_sw_clk <= 1'b0;
    end else begin
      o_sw_clk <= div_clk;                                        // R03 R04
    end
  end

  // ****************************************************************
  // Link domain: frame shifter on the clock pin's pad level
  // ****************************************************************
  psp_sync #(.WIDTH(2)) u_sync_link (
    .i_clk   (i_clk_link),
    .i_rst   (i_rst),
    .i_async ({req_tgl_reg, soft_clr_reg}),
    .o_sync  (lsync)
  );

  // Falling edges only: the switch samples on the rising edge, so data is
  // half a period old there; a stopped clock simply freezes the frame
  always_ff @(negedge i_clk_link or posedge i_rst) begin
    if (i_rst) begin
      lstate_reg  <= LS_IDLE;
      shift_reg   <= '0;
      cnt_reg     <= '0;
      seen_reg    <= 1'b0;
      ack_tgl_reg <= 1'b0;
      o_sw_data   <= 1'b0;
      o_sw_strobe <= 1'b0;
    end else if (lsync[0]) begin
      lstate_reg  <= LS_IDLE;
      seen_reg    <= lsync[1];
      ack_tgl_reg <= lsync[1];
      o_sw_strobe <= 1'b0;
    end else begin
      unique case (lstate_reg)
        LS_IDLE: begin
          if (lsync[1] != seen_reg) begin
            seen_reg   <= lsync[1];
            shift_reg  <= frame_reg;
            o_sw_data  <= frame_reg[FRAME_W-1];                   // R05 R12
            cnt_reg    <= CNT_W'(FRAME_W - 1);
            lstate_reg <= LS_SHIFT;
          end
        end
        LS_SHIFT: begin
          if (cnt_reg == '0) begin
            o_sw_strobe <= 1'b1;                                  // R06 R12
            lstate_reg  <= LS_STROBE;
          end else begin
            o_sw_data <= shift_reg[FRAME_W-2];                    // R01 R05
            shift_reg <= {shift_reg[FRAME_W-2:0], 1'b0};
            cnt_reg   <= cnt_reg - 1'b1;
          end
        end
        LS_STROBE: begin
          o_sw_strobe <= 1'b0;
          ack_tgl_reg <= seen_reg;
          lstate_reg  <= LS_IDLE;
        end
        default: lstate_reg <= LS_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic [31:0] hold_cnt_reg;

  // Helper: system cycles since the divided clock last changed; parked at
  // all ones while stopped, so the first half period after a start counts
  // exactly like the later ones
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      hold_cnt_reg <= '0;
    end else if (!clk_drive) begin
      hold_cnt_reg <= '1;
    end else if (div_clk != o_sw_clk) begin
      hold_cnt_reg <= '0;
    end else begin
      hold_cnt_reg <= hold_cnt_reg + 1'b1;
    end
  end

  sequence s_last_bit;
    lstate_reg == LS_SHIFT && cnt_reg == '0;
  endsequence

  sequence s_strobe_pulse;
    o_sw_strobe ##1 !o_sw_strobe;
  endsequence

  clk_input_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R02
    !clk_drive |=> !o_sw_clk_oe)
    else $error("clock pin driven while direction bit is clear");

  clk_output_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R02
    clk_drive && !hiz |=> o_sw_clk_oe)
    else $error("clock pin not driven while direction bit is set");

  ring_rate_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R04
    clk_drive && $past(clk_drive) && div_clk != o_sw_clk && hold_cnt_reg != '0
      |-> hold_cnt_reg == 32'(RING_HALF_CYC - 1))
    else $error("ring clock half period is wrong");

  frame_shift_a: assert property (@(negedge i_clk_link) disable iff (i_rst || lsync[0]) // R05
    lstate_reg == LS_SHIFT && cnt_reg != '0 |=> o_sw_data == $past(shift_reg[FRAME_W-2]))
    else $error("serial data bit out of order");

  strobe_last_a: assert property (@(negedge i_clk_link) disable iff (i_rst || lsync[0]) // R06 R12
    s_last_bit |=> s_strobe_pulse)
    else $error("strobe not a single pulse after the last bit");

  strobe_early_a: assert property (@(negedge i_clk_link) disable iff (i_rst) // R12
    o_sw_strobe |-> lstate_reg == LS_STROBE && $stable(o_sw_data))
    else $error("strobe raised before the frame ended");

  eeprom_strap_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R07
    !strap_done_reg && !hiz && !soft_clr && strap_cnt_reg == 2'(PSP_STRAP_WAIT)
      |=> o_eeprom_route == !$past(sin_s.strobe) && !o_sw_strobe_oe)
    else $error("strap not captured from the strobe pin");

  reset_hiz_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R08 R09
    sin_s.global_reset_input || sin_s.bus_reset_input |=> !o_sw_data_oe && !o_sw_clk_oe && !o_sw_strobe_oe)
    else $error("output driven during reset");

  reset_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R08 R09
    soft_clr |=> sysctl_reg == PSP_SYSCTL_RST && !o_eeprom_route)
    else $error("registers not cleared by reset");

  suspend_keep_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R10
    sin_s.susp && !done |=> $stable(sysctl_reg) && !o_sw_data_oe)
    else $error("suspend lost register contents or drove a pin");

endmodule

// >>> sim/psp_switch_model.sv
/*
 * Behavioural model of the external card power switch: resolves the clock
 * and strobe pads, shifts data in on clock rise and latches on strobe rise.
 * Assumes the bench enables the switch's own clock only around the strap resets and frames.
 */
`timescale 1ns/1ps
module psp_switch_model (
  input  wire logic   i_run,
  input  wire logic   i_strap,
  input  wire logic   i_sw_clk,
  input  wire logic   i_sw_clk_oe,
  input  wire logic   i_sw_data,
  input  wire logic   i_sw_data_oe,
  input  wire logic   i_sw_strobe,
  input  wire logic   i_sw_strobe_oe,
  output logic        o_clk_pad,
  output logic        o_strobe_pad,
  output logic [15:0] o_word,
  output int          o_latches
);
  logic        own_clk;
  logic        last_data = 1'b0;
  logic [15:0] shift_reg;

  // ****************************************************************
  // Pads and own clock
  // ****************************************************************
  // 48 ns clock, phase offset, held low (pull-down) while not running
  initial begin
    own_clk = 1'b0;
    #3;
    forever begin
      #24;
      own_clk = i_run ? ~own_clk : 1'b0;
    end
  end
  // Clock pad follows whoever drives it; strobe pad falls to the strap
  assign o_clk_pad    = i_sw_clk_oe ? i_sw_clk : own_clk;
  assign o_strobe_pad = i_sw_strobe_oe ? i_sw_strobe : i_strap;

  // ****************************************************************
  // Capture
  // ****************************************************************
  // Remember the last driven bit so a floating line shows its inverse
  always @(i_sw_data or i_sw_data_oe) begin
    if (i_sw_data_oe) begin
      last_data = i_sw_data;
    end
  end
  // Sample only at clock rise, never in between
  always @(posedge o_clk_pad) begin
    shift_reg <= {shift_reg[14:0], i_sw_data_oe ? i_sw_data : ~last_data};
  end
  // Take the shifted word only when the strobe is really driven
  always @(posedge o_strobe_pad) begin
    if (i_sw_strobe_oe) begin
      o_word <= shift_reg;
      o_latches <= o_latches + 1;
    end
  end
endmodule

// >>> sim/tb.sv
/*
 * Self-checking bench of the power switch serial port: APB master tasks,
 * one task per scenario, the switch model on the pins.
 * Assumes the design answers APB with a wait state and loops the pad back.
 */
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module tb;
  import psp_pkg::*;
  localparam int HALF = 4;
  logic        i_clk_sys, i_rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        global_reset_input_pin, brst_pin, susp_pin, run, strap, clk_pad, strobe_pad;
  logic        sw_clk, sw_clk_oe, sw_data, sw_data_oe, sw_strobe, sw_strobe_oe, route;
  logic [15:0] word;
  int          latches, num_errors, checks;

  // ****************************************************************
  // Design and switch
  // ****************************************************************
  psp_top #(.FRAME_W(16), .RING_HALF_CYC(HALF)) u_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_global_reset_input(global_reset_input_pin),
    .i_bus_reset_input(brst_pin), .i_suspend_mode(susp_pin), .i_clk_link(clk_pad),
    .o_sw_clk(sw_clk), .o_sw_clk_oe(sw_clk_oe), .o_sw_data(sw_data), .o_sw_data_oe(sw_data_oe),
    .i_sw_strobe(strobe_pad), .o_sw_strobe(sw_strobe), .o_sw_strobe_oe(sw_strobe_oe),
    .o_eeprom_route(route));
  psp_switch_model u_sw (.i_run(run), .i_strap(strap), .i_sw_clk(sw_clk), .i_sw_clk_oe(sw_clk_oe),
    .i_sw_data(sw_data), .i_sw_data_oe(sw_data_oe), .i_sw_strobe(sw_strobe),
    .i_sw_strobe_oe(sw_strobe_oe), .o_clk_pad(clk_pad), .o_strobe_pad(strobe_pad),
    .o_word(word), .o_latches(latches));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Poll status until the frame has gone out
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, PSP_STATUS_OFF, PSP_ZERO_WORD);
      n++;
    end while (rd[PSP_ST_BUSY] !== 1'b0 && n < 200);
    if (n >= 200) begin
      num_errors++;
      close_out();
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Strap read at reset release, both pad levels; link clock runs to reset the shifter
  task automatic t_strap();
    cyc(2);
    `CHK({sw_clk_oe, sw_data_oe, sw_strobe_oe}, 3'b010)
    for (int s = 0; s < 2; s++) begin
      strap <= s[0];
      i_rst <= 1'b1;
      cyc(24);
      `CHK({sw_clk_oe, sw_data_oe, sw_strobe_oe}, 3'b000)
      i_rst <= 1'b0;
      cyc(10);
      `CHK(route, ~s[0])
      `CHK(sw_strobe_oe, 1'b1)
    end
    run <= 1'b0;
    $display("test strap done");
  endtask
  // Register reset value, RW, unmapped place, clock direction and ring rate
  task automatic t_regs();
    int n;
    logic c0;
    apb(1'b0, PSP_SYSCTL_OFF, PSP_ZERO_WORD);
    `CHK(rd, PSP_SYSCTL_RST)
    `CHK(sw_clk_oe, 1'b0)
    apb(1'b0, 8'h40, PSP_ZERO_WORD);
    `CHK({err, rd}, {1'b1, PSP_ZERO_WORD})
    apb(1'b1, PSP_SYSCTL_OFF, 32'hF7FF_FFFF);
    apb(1'b0, PSP_SYSCTL_OFF, PSP_ZERO_WORD);
    `CHK({rd, sw_clk_oe}, {32'hF7FF_FFFF, 1'b0})
    apb(1'b1, PSP_SYSCTL_OFF, 32'h0800_0000);
    cyc(2);
    `CHK(sw_clk_oe, 1'b1)
    for (int k = 0; k < 2; k++) begin
      c0 = sw_clk;
      n = 0;
      while (sw_clk === c0 && n < 100) begin
        @(posedge i_clk_sys);
        n++;
      end
    end
    `CHK(n, HALF)
    apb(1'b1, PSP_SYSCTL_OFF, PSP_ZERO_WORD);
    cyc(2);
    `CHK(sw_clk_oe, 1'b0)
    $display("test regs done");
  endtask
  // Frames MSB first, second write while busy dropped, one strobe each
  task automatic t_frame();
    logic [15:0] vals [2];
    int n0;
    vals = '{16'hA5C3, 16'h8001};
    run <= 1'b1;
    foreach (vals[i]) begin
      n0 = latches;
      apb(1'b1, PSP_FRAME_OFF, {16'h0000, vals[i]});
      apb(1'b1, PSP_FRAME_OFF, {16'h0000, ~vals[i]});
      wait_idle();
      `CHK(word, vals[i])
      `CHK(latches, n0 + 1)
    end
    run <= 1'b0;
    $display("test frame done");
  endtask
  // Pin reset floats outputs and clears registers
  task automatic t_pin_reset(input logic bus);
    apb(1'b1, PSP_SYSCTL_OFF, 32'h0800_0001);
    if (bus) brst_pin <= 1'b1;
    else global_reset_input_pin <= 1'b1;
    cyc(6);
    `CHK({sw_clk_oe, sw_data_oe, sw_strobe_oe}, 3'b000)
    global_reset_input_pin <= 1'b0;
    brst_pin <= 1'b0;
    cyc(6);
    apb(1'b0, PSP_SYSCTL_OFF, PSP_ZERO_WORD);
    `CHK(rd, PSP_SYSCTL_RST)
    $display("test pin reset done");
  endtask
  // Suspend floats outputs, ignores a global reset, keeps contents
  task automatic t_suspend();
    apb(1'b1, PSP_SYSCTL_OFF, 32'h0800_00A5);
    susp_pin <= 1'b1;
    cyc(6);
    `CHK({sw_clk_oe, sw_data_oe, sw_strobe_oe}, 3'b000)
    apb(1'b0, PSP_STATUS_OFF, PSP_ZERO_WORD);
    `CHK({rd[PSP_ST_HIZ], rd[PSP_ST_SUSP], rd[PSP_ST_STRAP], rd[PSP_ST_BUSY]}, 4'b1100)
    global_reset_input_pin <= 1'b1;
    cyc(6);
    global_reset_input_pin <= 1'b0;
    cyc(6);
    susp_pin <= 1'b0;
    cyc(6);
    `CHK(sw_clk_oe, 1'b1)
    apb(1'b0, PSP_SYSCTL_OFF, PSP_ZERO_WORD);
    `CHK(rd, 32'h0800_00A5)
    $display("test suspend done");
  endtask

  // ****************************************************************
  // Clock and main sequence
  // ****************************************************************
  always #2.5 i_clk_sys = ~i_clk_sys;
  // Global reset pin used twice, the second time under suspend; bus reset once in between
  initial begin
    {i_clk_sys, psel, penable, pwrite, global_reset_input_pin, brst_pin, susp_pin} = 7'b0000000;
    {i_rst, run, strap} = 3'b111;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    num_errors = 0;
    checks = 0;
    repeat (8) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    t_strap();
    t_regs();
    t_frame();
    t_pin_reset(1'b0);
    t_pin_reset(1'b1);
    t_suspend();
    close_out();
  end
endmodule
